// ---- edp_pwr_pkg.sv ----
package edp_pwr_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int BLACK_MAX_MS = 200;
  localparam int HPD_MAX_MS = 200;
  localparam int VIDEO_ON_MAX_MS = 50;
  localparam int BLACK_ON_LOSS_MS = 50;
  localparam int PWR_OFF_MAX_MS = 500;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int HPD_CYC = HPD_MAX_MS * CYC_PER_MS / 2;
  localparam int LOSS_CYC = BLACK_ON_LOSS_MS * CYC_PER_MS / 2;
  localparam int PWROFF_CYC = PWR_OFF_MAX_MS * CYC_PER_MS / 2;
  localparam int H_ACTIVE = 1920;
  localparam int V_ACTIVE = 1080;
  localparam int H_TOTAL = 2192;
  localparam int V_TOTAL = 1160;
  localparam int NO_VIDEO_BIT = 3;
  localparam int PIX_W = 24;
  localparam int LINK_DIV = 25;
  typedef enum logic [2:0] {
    SNK_OFF = 3'b000,
    SNK_INIT = 3'b001,
    SNK_BLACK = 3'b011,
    SNK_VIDEO = 3'b010
  } sink_state_e;
  typedef enum logic [2:0] {
    SRC_OFF = 3'b000,
    SRC_WAIT_HPD = 3'b001,
    SRC_TRAIN = 3'b011,
    SRC_IDLE = 3'b010,
    SRC_VIDEO = 3'b110,
    SRC_BL_ON = 3'b111,
    SRC_DOWN = 3'b101
  } source_state_e;
endpackage

// ---- edp_link_if.sv ----
`timescale 1ns/10ps
interface edp_link_if;
  logic panel_logic_supply;
  logic hpd;
  logic aux_req;
  logic aux_ack;
  logic link_clk;
  logic pix_valid;
  logic [23:0] pix_data;
  logic pix_sof;
  logic no_video;
  logic stream_active;
  modport sink (input panel_logic_supply, aux_req, link_clk, pix_valid, pix_data, pix_sof,
    no_video, stream_active, output hpd, aux_ack);
  modport source (output panel_logic_supply, aux_req, link_clk, pix_valid, pix_data, pix_sof,
    no_video, stream_active, input hpd, aux_ack);
endinterface

// ---- edp_source.sv ----
`timescale 1ns/10ps
module edp_source #(
  parameter int PWROFF_CYCLES = edp_pwr_pkg::PWROFF_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  edp_link_if.source link,
  input wire logic power_req,
  input wire logic pix_in_valid,
  input wire logic [edp_pwr_pkg::PIX_W-1:0] pix_in_data,
  output logic pix_in_ready,
  output logic backlight_en
);
  import edp_pwr_pkg::*;
  source_state_e state;
  logic [31:0] cnt;
  logic [4:0] div;
  logic [1:0] hpd_s;
  logic [1:0] ack_s;
  logic [11:0] hcnt;
  logic [1:0] bl_cnt;
  if (PWROFF_CYCLES < 1) begin
    $error("bad power-off count");
  end
  // ready is a flop; a word can still be taken in the cycle power_req falls, none after
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pix_in_ready <= 1'b0;
    end else begin
      pix_in_ready <= (state == SRC_VIDEO || state == SRC_BL_ON) && power_req
        && div == 5'(LINK_DIV - 1);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hpd_s <= 2'b00;
      ack_s <= 2'b00;
    end else begin
      hpd_s <= {hpd_s[0], link.hpd};
      ack_s <= {ack_s[0], link.aux_ack};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !link.panel_logic_supply) begin
      div <= 5'd0;
      link.link_clk <= 1'b0;
    end else if (div == 5'(LINK_DIV - 1)) begin
      div <= 5'd0;
      link.link_clk <= ~link.link_clk;
    end else begin
      div <= div + 5'd1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= SRC_OFF;
      cnt <= 32'd0;
      link.panel_logic_supply <= 1'b0;
      link.aux_req <= 1'b0;
      link.pix_valid <= 1'b0;
      link.pix_data <= 24'h00_0000;
      link.pix_sof <= 1'b0;
      link.no_video <= 1'b0;
      link.stream_active <= 1'b0;
      backlight_en <= 1'b0;
      hcnt <= 12'd0;
      bl_cnt <= 2'd0;
    end else begin
      case (state)
        SRC_OFF: begin
          link.aux_req <= 1'b0;
          if (power_req) begin
            link.panel_logic_supply <= 1'b1;
            state <= SRC_WAIT_HPD;
          end
        end
        SRC_WAIT_HPD: begin
          link.aux_req <= 1'b1; // capability read retried until answered [RULE_05] [RULE_15]
          if (hpd_s[1] && ack_s[1]) begin
            link.aux_req <= 1'b0;
            state <= SRC_TRAIN;
          end
        end
        SRC_TRAIN: begin
          link.stream_active <= 1'b1;
          state <= SRC_IDLE;
          cnt <= 32'd0;
        end
        SRC_IDLE: begin
          cnt <= cnt + 32'd1; // idle pattern time [RULE_06]
          if (cnt == 32'(LINK_DIV * 4)) state <= SRC_VIDEO;
        end
        SRC_VIDEO, SRC_BL_ON: begin
          if (pix_in_ready) begin
            // a word stands for a whole link half period, so the far end takes it on an edge
            link.pix_valid <= pix_in_valid;
            link.pix_data <= pix_in_data;
            link.pix_sof <= pix_in_valid && hcnt == 12'd0;
          end
          if (pix_in_valid && pix_in_ready) begin
            hcnt <= (hcnt == 12'(H_TOTAL - 1)) ? 12'd0 : hcnt + 12'd1; // [RULE_20]
            if (bl_cnt != 2'd3) bl_cnt <= bl_cnt + 2'd1;
          end
          if (state == SRC_VIDEO && bl_cnt == 2'd3) begin
            backlight_en <= 1'b1; // only after stable video [RULE_07]
            state <= SRC_BL_ON;
          end
          if (!power_req) begin
            backlight_en <= 1'b0; // dark before video ends [RULE_08]
            state <= SRC_DOWN;
            cnt <= 32'd0;
          end
        end
        SRC_DOWN: begin
          link.pix_valid <= 1'b0;
          link.pix_data <= 24'h00_0000;
          link.pix_sof <= 1'b0;
          link.no_video <= 1'b1;
          cnt <= cnt + 32'd1;
          if (cnt == 32'(PWROFF_CYCLES)) begin
            link.panel_logic_supply <= 1'b0; // [RULE_09]
            link.stream_active <= 1'b0; // all low with power off [RULE_17]
            link.no_video <= 1'b0;
            bl_cnt <= 2'd0;
            hcnt <= 12'd0;
            state <= SRC_OFF;
          end
        end
        default: state <= SRC_OFF;
      endcase
    end
  end
endmodule

// ---- edp_sink.sv ----
`timescale 1ns/10ps
// Functional notes
// [RULE_01] black video within 200ms of power
// [RULE_02] raise hot-plug within 200ms
// [RULE_03] aux ready whenever hot-plug high
// [RULE_04] valid video shown within 50ms
// [RULE_05] source reads capabilities before training
// [RULE_06] source sends idle pattern before video
// [RULE_07] backlight only after stable video
// [RULE_08] backlight dark before video stops
// [RULE_09] power removed within 500ms after video
// [RULE_10] no-video flag forces black
// [RULE_11] missing or invalid video: black in 50ms
// [RULE_12] validity judged from stream timing
// [RULE_13] debug control disables auto black
// [RULE_14] early aux polling tolerated safely
// [RULE_15] source retries unanswered aux polls
// [RULE_16] aux answers within 200ms of power
// [RULE_17] source holds signals low while unpowered
// [RULE_18] both link rates supported
// [RULE_19] accept 1920 by 1080 RGB frames
// [RULE_20] source sends 2192 by 1160 totals; source wraps lines at 2192, keeps no 1160-line count
// [RULE_21] power-up clears valid, hot-plug low
// [RULE_22] recovered video leaves black mode
module edp_sink #(
  parameter int HPD_CYCLES = edp_pwr_pkg::HPD_CYC,
  parameter int LOSS_CYCLES = edp_pwr_pkg::LOSS_CYC,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  edp_link_if.sink link,
  input wire logic black_disable,
  input wire logic out_ready,
  output logic out_valid,
  output logic [edp_pwr_pkg::PIX_W-1:0] out_data,
  output logic black_active
);
  import edp_pwr_pkg::*;
  sink_state_e state;
  logic [1:0] sup_s;
  logic [1:0] lclk_s;
  logic [1:0] pv_s;
  logic [1:0] nv_s;
  logic [1:0] act_s;
  logic [1:0] req_s;
  logic [PIX_W-1:0] pd_s0;
  logic [PIX_W-1:0] pd_s1;
  logic [1:0] sof_s;
  logic lclk_d;
  logic [31:0] tmr;
  logic [31:0] loss;
  logic [11:0] pcnt;
  logic timing_ok;
  logic video_ok;
  logic [PIX_W-1:0] buf_mem [DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] fill;
  logic in_fire;
  logic supply;
  logic link_edge;
  logic take;
  logic give;
  // black wins unless the debug control keeps the picture up
  function automatic logic shows_picture(sink_state_e s, logic keep);
    return s == SNK_VIDEO || keep;
  endfunction
  // the buffer and timers cannot serve other values
  if (DEPTH != 2 || HPD_CYCLES < 1 || LOSS_CYCLES < 1) begin
    $error("bad parameter");
  end
  assign supply = sup_s[1];
  // one pulse per seen link edge; the word launched after the previous edge is settled by then
  assign link_edge = lclk_s[1] != lclk_d;
  assign take = link_edge && pv_s[1] && in_fire;
  assign give = (!out_valid || out_ready) && fill != 2'd0;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sup_s <= 2'b00;
      lclk_s <= 2'b00;
      pv_s <= 2'b00;
      nv_s <= 2'b00;
      act_s <= 2'b00;
      req_s <= 2'b00;
      sof_s <= 2'b00;
      pd_s0 <= '0;
      pd_s1 <= '0;
      lclk_d <= 1'b0;
    end else begin
      sup_s <= {sup_s[0], link.panel_logic_supply};
      lclk_s <= {lclk_s[0], link.link_clk};
      pv_s <= {pv_s[0], link.pix_valid};
      nv_s <= {nv_s[0], link.no_video};
      act_s <= {act_s[0], link.stream_active};
      req_s <= {req_s[0], link.aux_req};
      sof_s <= {sof_s[0], link.pix_sof};
      pd_s0 <= link.pix_data;
      pd_s1 <= pd_s0;
      lclk_d <= lclk_s[1];
    end
  end
  // any loss of the synced supply behaves as a power-on reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply) begin
      state <= SNK_OFF; // [RULE_21]
      tmr <= 32'd0;
      link.hpd <= 1'b0;
    end else begin
      case (state)
        SNK_OFF: begin
          tmr <= 32'd0;
          state <= SNK_INIT;
        end
        SNK_INIT: begin
          tmr <= tmr + 32'd1;
          if (tmr == 32'(HPD_CYCLES)) begin
            link.hpd <= 1'b1; // aux answers from the cycle after hot-plug rises [RULE_02] [RULE_03]
            state <= SNK_BLACK;
          end
        end
        SNK_BLACK: begin
          if (video_ok) state <= SNK_VIDEO; // [RULE_22]
        end
        SNK_VIDEO: begin
          if (!video_ok && !black_disable) state <= SNK_BLACK; // [RULE_13]
        end
        default: state <= SNK_OFF;
      endcase
    end
  end
  // answers only once past init; an early poll sees silence, never a half-ready reply
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply) begin
      link.aux_ack <= 1'b0; // polls before ready simply go unanswered [RULE_14]
    end else begin
      link.aux_ack <= req_s[1] && state != SNK_OFF && state != SNK_INIT; // [RULE_16]
    end
  end
  // line length check stands in for full attribute parsing; pixels from either link rate
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply) begin
      pcnt <= 12'd0;
      timing_ok <= 1'b0;
    end else if (link_edge && pv_s[1]) begin
      if (sof_s[1]) begin
        timing_ok <= pcnt == 12'(H_TOTAL - 1) || pcnt == 12'd0; // [RULE_12] [RULE_18]
        pcnt <= 12'd0;
      end else begin
        pcnt <= pcnt + 12'd1;
      end
    end
  end
  // validity is lost on the no-video flag, a stopped stream or a silent link
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply) begin
      loss <= 32'd0;
      video_ok <= 1'b0; // [RULE_21]
    end else if (nv_s[1] || !act_s[1]) begin
      video_ok <= 1'b0; // [RULE_10]
      loss <= 32'd0;
    end else if (link_edge && pv_s[1]) begin
      loss <= 32'd0;
      video_ok <= timing_ok; // [RULE_04]
    end else if (loss == 32'(LOSS_CYCLES)) begin
      video_ok <= 1'b0; // [RULE_11]
    end else begin
      loss <= loss + 32'd1;
    end
  end
  assign in_fire = fill != 2'd2;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply) begin
      black_active <= 1'b1;
    end else begin
      black_active <= !shows_picture(state, black_disable); // [RULE_01]
    end
  end
  // no back-pressure on the link, so a word that meets a full buffer is dropped
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply) begin
      wr_ptr <= 1'b0;
    end else if (take) begin
      buf_mem[wr_ptr] <= pd_s1; // [RULE_19]
      wr_ptr <= ~wr_ptr;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply) begin
      fill <= 2'd0;
    end else begin
      fill <= fill + 2'(take) - 2'(give);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !supply) begin
      rd_ptr <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (!out_valid || out_ready) begin
      out_valid <= fill != 2'd0;
      out_data <= shows_picture(state, black_disable) ? buf_mem[rd_ptr] : '0;
      if (give) rd_ptr <= ~rd_ptr;
    end else if (!shows_picture(state, black_disable)) begin
      out_data <= '0; // a held word is blanked too, so black never shows a stale pixel
    end
  end
endmodule

// ---- edp_link_props.sv ----
`timescale 1ns/10ps
module edp_link_props #(
  parameter int HPD_CYCLES = 100,
  parameter int PWROFF_CYCLES = 150
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic panel_logic_supply,
  input wire logic hpd,
  input wire logic aux_req,
  input wire logic aux_ack,
  input wire logic pix_valid,
  input wire logic stream_active,
  input wire logic no_video
);
  // margin covers the sink's two-flop input sync
  localparam int HPD_WAIT = HPD_CYCLES + 8;
  localparam int OFF_WAIT = PWROFF_CYCLES + 8;
  logic aux_seen;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !panel_logic_supply) aux_seen <= 1'b0;
    else if (aux_ack) aux_seen <= 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_hpd_in_time: assert property ($rose(panel_logic_supply) |-> ##[1:HPD_WAIT] hpd)
    else $error("hot-plug late after supply");
  a_hpd_needs_power: assert property ($rose(hpd) |-> panel_logic_supply)
    else $error("hot-plug raised without supply");
  a_hpd_stands: assert property (hpd && panel_logic_supply |=> hpd)
    else $error("hot-plug dropped while powered");
  a_aux_answer: assert property (hpd && aux_req |-> ##[0:6] aux_ack)
    else $error("aux poll not answered");
  a_no_early_ack: assert property (aux_ack |-> hpd)
    else $error("aux answer before hot-plug");
  a_train_after_aux: assert property ($rose(stream_active) |-> aux_seen)
    else $error("stream before aux read");
  a_pix_in_stream: assert property (pix_valid |-> stream_active)
    else $error("pixel outside stream");
  a_unpowered_quiet: assert property (!panel_logic_supply && !$past(panel_logic_supply)
    |-> !pix_valid && !stream_active && !aux_req)
    else $error("link driven while unpowered");
  a_off_in_time: assert property ($rose(no_video) |-> ##[0:OFF_WAIT]
    !panel_logic_supply)
    else $error("supply not removed in time");
  c_hpd: cover property ($rose(hpd));
  c_stream: cover property ($rose(stream_active));
  c_power_off: cover property ($fell(panel_logic_supply));
endmodule

// ---- tb_edp_sink_power_black_video.sv ----
`timescale 1ns/10ps
module tb_edp_sink_power_black_video;
  import edp_pwr_pkg::*;
  // short counts keep the run well under the cycle budget
  localparam int HPD_P = 100;
  localparam int LOSS_P = 200;
  localparam int OFF_P = 150;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic power_req = 1'b0;
  logic pix_in_valid = 1'b0;
  logic [PIX_W-1:0] pix_in_data = '0;
  logic black_disable = 1'b0;
  logic out_ready = 1'b1;
  logic pix_in_ready, backlight_en, out_valid, black_active, taken;
  logic [PIX_W-1:0] out_data;
  logic [PIX_W-1:0] k = '0;
  bit feed = 0, hold = 0, stall = 0, ok = 0;
  int miscompares = 0;
  int n_tests = 0;
  edp_link_if link ();
  edp_source #(.PWROFF_CYCLES(OFF_P)) edp_source_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(link), .power_req(power_req), .pix_in_valid(pix_in_valid),
    .pix_in_data(pix_in_data), .pix_in_ready(pix_in_ready), .backlight_en(backlight_en));
  edp_sink #(.HPD_CYCLES(HPD_P), .LOSS_CYCLES(LOSS_P), .DEPTH(2)) edp_sink_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .black_disable(black_disable),
    .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data),
    .black_active(black_active));
  edp_link_props #(.HPD_CYCLES(HPD_P), .PWROFF_CYCLES(OFF_P)) edp_link_props_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .panel_logic_supply(link.panel_logic_supply),
    .hpd(link.hpd), .aux_req(link.aux_req), .aux_ack(link.aux_ack),
    .pix_valid(link.pix_valid), .stream_active(link.stream_active), .no_video(link.no_video));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [PIX_W-1:0] exp_word(logic blk, logic [PIX_W-1:0] d);
    return blk ? '0 : d;
  endfunction
  function automatic logic sig(int i);
    case (i)
      0: return link.hpd;
      1: return black_active;
      2: return backlight_en;
      4: return out_valid;
      default: return link.panel_logic_supply;
    endcase
  endfunction
  task automatic chk1(string name, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk24(string name, logic [PIX_W-1:0] exp, logic [PIX_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_sig(int i, logic v, int n);
    ok = 0;
    for (int c = 0; c < n && !ok; c++) begin
      @(negedge clk_sys);
      ok = (sig(i) === v);
    end
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // word is held until the edge that takes it
  always @(posedge clk_sys) taken <= pix_in_valid && pix_in_ready;
  always @(negedge clk_sys) begin
    if (feed && (!pix_in_valid || taken)) begin
      pix_in_valid <= 1'b1;
      pix_in_data <= hold ? k : PIX_W'($urandom);
    end else if (!feed && (!pix_in_valid || taken)) pix_in_valid <= 1'b0;
    out_ready <= !stall && ($urandom_range(3) != 0);
    if (!sys_rst && out_valid === 1'b1 && black_active === 1'b1) begin
      chk24("black data", exp_word(1'b1, out_data), out_data);
    end
  end
  initial begin
    void'($urandom(32'h4082));
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk1("hpd at reset", 1'b0, link.hpd);
    chk1("black at reset", 1'b1, black_active);
    chk1("out_valid at reset", 1'b0, out_valid);
    power_req = 1'b1;
    feed = 1;
    wait_sig(0, 1'b1, HPD_P + 60);
    chk1("hpd rise", 1'b1, ok);
    chk1("black before video", 1'b1, black_active);
    stall = 1;
    repeat (300) @(negedge clk_sys);
    stall = 0;
    wait_sig(1, 1'b0, 70000);
    chk1("video shown", 1'b1, ok);
    wait_sig(2, 1'b1, 2000);
    chk1("backlight on", 1'b1, ok);
    k = PIX_W'($urandom);
    hold = 1;
    repeat (400) @(negedge clk_sys);
    wait_sig(4, 1'b1, 400);
    chk24("pixel", exp_word(1'b0, k), out_data);
    feed = 0;
    wait_sig(1, 1'b1, LOSS_P + 120);
    chk1("black on loss", 1'b1, ok);
    feed = 1;
    wait_sig(1, 1'b0, 200);
    chk1("video recovered", 1'b1, ok);
    black_disable = 1'b1;
    feed = 0;
    repeat (2 * LOSS_P) @(negedge clk_sys);
    chk1("black held off", 1'b0, black_active);
    black_disable = 1'b0;
    wait_sig(1, 1'b1, 40);
    chk1("black on release", 1'b1, ok);
    feed = 1;
    wait_sig(1, 1'b0, 200);
    chk1("video before off", 1'b1, ok);
    power_req = 1'b0;
    wait_sig(2, 1'b0, 200);
    chk1("backlight off", 1'b1, ok);
    chk1("supply still on", 1'b1, link.panel_logic_supply);
    wait_sig(1, 1'b1, 20);
    chk1("black on no-video", 1'b1, ok);
    feed = 0;
    wait_sig(3, 1'b0, OFF_P + 60);
    chk1("supply off", 1'b1, ok);
    wait_sig(0, 1'b0, 20);
    chk1("hpd low", 1'b1, ok);
    chk1("black after off", 1'b1, black_active);
    report_and_stop();
  end
  initial begin
    repeat (95000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end
endmodule
